/* File: logic/dccum_pkg.sv */
// Constants shared by the clear-code and update-mask register block
`default_nettype none
package dccum_pkg;
   // Serial frame layout
   localparam int unsigned FRAME_BITS = 32;
   localparam int unsigned CNT_W      = 6;
   localparam logic [5:0]  LAST_BIT   = 6'h1f;
   localparam int unsigned CMD_HI     = 27;
   localparam int unsigned CMD_LO     = 24;
   localparam int unsigned SEL_HI     = 1;
   localparam int unsigned SEL_LO     = 0;
   localparam int unsigned MASK_HI    = 3;
   localparam int unsigned MASK_LO    = 0;
   localparam int unsigned NCH        = 4;

   // Commands
   localparam logic [3:0] CMD_CLEAR_CODE  = 4'h5;
   localparam logic [3:0] CMD_UPDATE_MASK = 4'h6;

   // Clear-code selections and the codes they load
   localparam logic [1:0]  SEL_ZERO  = 2'h0;
   localparam logic [1:0]  SEL_MID   = 2'h1;
   localparam logic [1:0]  SEL_FULL  = 2'h2;
   localparam logic [1:0]  SEL_NOP   = 2'h3;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID  = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;

   // Reset values
   localparam logic [1:0] SEL_RESET  = SEL_ZERO;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Pin synchroniser positions
   localparam int unsigned PIN_SCLK  = 0;
   localparam int unsigned PIN_SYNC  = 1;
   localparam int unsigned PIN_SDIN  = 2;
   localparam int unsigned PIN_CLR   = 3;
   localparam int unsigned PIN_LOAD  = 4;
   localparam int unsigned NPINS     = 5;
   localparam logic [4:0]  PIN_IDLE  = 5'h1b;

   typedef enum logic [2:0] {
      SH_IDLE  = 3'h1,
      SH_SHIFT = 3'h2,
      SH_HOLD  = 3'h4
   } dccum_shst_t;
endpackage
`default_nettype wire

/* File: logic/dccum_frame_if.sv */
// Carrier between the pin front end and the serial frame shifter
`default_nettype none
interface dccum_frame_if;
   logic        sclk_fall;
   logic        sync_n;
   logic        sdin;
   logic        abort;
   logic        done;
   logic [31:0] word;
   modport shifter (input sclk_fall, input sync_n, input sdin, input abort,
                    output done, output word);
   modport decoder (output sclk_fall, output sync_n, output sdin, output abort,
                    input done, input word);
endinterface
`default_nettype wire

/* File: logic/dccum_shift.sv */
// Serial frame shifter: collects 32 bits on falling serial-clock edges
`default_nettype none
module dccum_shift
   import dccum_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst,
   dccum_frame_if.shifter frm
);
   dccum_shst_t             st_r;
   logic [CNT_W-1:0]        cnt_r;
   logic [FRAME_BITS-1:0]   sh_r;
   logic [FRAME_BITS-1:0]   word_r;
   logic                    done_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame state; an aborted or completed frame waits for the strobe to rise
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= SH_IDLE;
      end else begin
         case (st_r)
            SH_IDLE: begin
               // A clear before the first edge still discards the whole frame
               if (!frm.sync_n && frm.abort) begin
                  st_r <= SH_HOLD; // RQ7
               end else if (!frm.sync_n) begin
                  st_r <= SH_SHIFT;
               end
            end
            SH_SHIFT: begin
               if (frm.sync_n) begin
                  st_r <= SH_IDLE;
               end else if (frm.abort) begin
                  st_r <= SH_HOLD; // RQ7
               end else if (frm.sclk_fall && cnt_r == LAST_BIT) begin
                  st_r <= SH_HOLD;
               end
            end
            SH_HOLD: begin
               if (frm.sync_n) begin
                  st_r <= SH_IDLE;
               end
            end
            default: st_r <= SH_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit counter and shift register
   always_ff @(posedge clk) begin
      if (rst || st_r != SH_SHIFT) begin
         cnt_r <= '0;
      end else if (frm.sclk_fall) begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sh_r <= '0;
      end else if (st_r == SH_SHIFT && frm.sclk_fall) begin
         sh_r <= {sh_r[FRAME_BITS-2:0], frm.sdin};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Completed word, offered with a one-cycle pulse on the 32nd edge
   always_ff @(posedge clk) begin
      if (rst) begin
         done_r <= 1'b0;
         word_r <= '0;
      end else begin
         done_r <= 1'b0;
         if (st_r == SH_SHIFT && frm.sclk_fall && cnt_r == LAST_BIT
             && !frm.abort && !frm.sync_n) begin
            done_r <= 1'b1;
            word_r <= {sh_r[FRAME_BITS-2:0], frm.sdin};
         end
      end
   end

   assign frm.done = done_r;
   assign frm.word = word_r;
endmodule
`default_nettype wire

/* File: logic/dccum_top.sv */
// Clear-code selection and per-channel update override mask of a quad DAC
// Contract
// RQ1 - Selection 00 clears to 0x0000, 01 to 0x8000, 10 to 0xffff, 11 none.
// RQ2 - Command 0101 in bits 27..24 loads selection from bits 1..0.
// RQ3 - Mask bit 0: channel update follows the hardware load strobe pin.
// RQ4 - Mask bit 1: channel updates regardless, as if load strobe low.
// RQ5 - Command 0110 loads mask; bits 3..0 are channels D, C, B, A.
// RQ6 - Clear falling edge loads input and DAC registers with chosen code.
// RQ7 - Clear mode ends at next write's 32nd edge; clear aborts writes.
// RQ8 - After reset mask is zero and selection clears to zero scale.
`default_nettype none
module dccum_top
   import dccum_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        SCLK,
   input  wire logic        SYNC_N,
   input  wire logic        SDIN,
   input  wire logic        ASYNC_CLEAR_N,
   input  wire logic        LOAD_STROBE_N,
   output var  logic [1:0]  CLEAR_SEL,
   output var  logic [3:0]  UPDATE_MASK,
   output var  logic [15:0] CLEAR_CODE,
   output var  logic        CLEAR_LOAD,
   output var  logic        CLEAR_MODE,
   output var  logic [3:0]  CH_UPDATE_EN,
   output var  logic        FRAME_VALID,
   output var  logic [31:0] FRAME_WORD,
   output var  logic        FRAME_ABORT
);
   logic [NPINS-1:0]  meta_r;
   logic [NPINS-1:0]  pin_r;
   logic              sclk_d_r;
   logic              clr_d_r;
   logic              clr_fall;
   logic              in_frame;
   logic [3:0]        cmd;
   logic [1:0]        sel_r;
   logic [3:0]        mask_r;
   logic [15:0]       code_nxt;
   logic              clr_load_r;
   logic              clr_mode_r;
   logic [3:0]        upd_r;
   logic              fvalid_r;
   logic [31:0]       fword_r;
   logic              fabort_r;

   dccum_frame_if frm ();

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage and its delayed copy are read
   always_ff @(posedge MCLK) begin
      if (RST) begin
         meta_r <= PIN_IDLE;
         pin_r  <= PIN_IDLE;
      end else begin
         meta_r <= {LOAD_STROBE_N, ASYNC_CLEAR_N, SDIN, SYNC_N, SCLK};
         pin_r  <= meta_r;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         sclk_d_r <= 1'b1;
         clr_d_r  <= 1'b1;
      end else begin
         sclk_d_r <= pin_r[PIN_SCLK];
         clr_d_r  <= pin_r[PIN_CLR];
      end
   end

   assign clr_fall = clr_d_r && !pin_r[PIN_CLR];
   assign in_frame = !pin_r[PIN_SYNC];

   // Clear is checked before the shifter sees an edge, so a clear in flight wins
   assign frm.sclk_fall = sclk_d_r && !pin_r[PIN_SCLK];
   assign frm.sync_n    = pin_r[PIN_SYNC];
   assign frm.sdin      = pin_r[PIN_SDIN];
   assign frm.abort     = clr_fall; // RQ7

   dccum_shift u_shift (
      .clk (MCLK),
      .rst (RST),
      .frm (frm)
   );

   assign cmd = frm.word[CMD_HI:CMD_LO];

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers; address and don't-care bits are not decoded
   always_ff @(posedge MCLK) begin
      if (RST) begin
         sel_r <= SEL_RESET; // RQ8
      end else if (frm.done && cmd == CMD_CLEAR_CODE) begin
         sel_r <= frm.word[SEL_HI:SEL_LO]; // RQ2
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         mask_r <= MASK_RESET; // RQ8
      end else if (frm.done && cmd == CMD_UPDATE_MASK) begin
         mask_r <= frm.word[MASK_HI:MASK_LO]; // RQ5
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clear code lookup
   always_comb begin
      case (sel_r)
         SEL_ZERO: code_nxt = CODE_ZERO; // RQ1
         SEL_MID:  code_nxt = CODE_MID; // RQ1
         SEL_FULL: code_nxt = CODE_FULL; // RQ1
         default:  code_nxt = CODE_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clear event: one pulse loads every input and DAC register
   always_ff @(posedge MCLK) begin
      if (RST) begin
         clr_load_r <= 1'b0;
      end else begin
         clr_load_r <= clr_fall && sel_r != SEL_NOP; // RQ6 RQ1
      end
   end

   // Set wins: a clear on the very edge that ends a write keeps the mode
   always_ff @(posedge MCLK) begin
      if (RST) begin
         clr_mode_r <= 1'b0;
      end else if (clr_fall && sel_r != SEL_NOP) begin
         clr_mode_r <= 1'b1;
      end else if (frm.done) begin
         clr_mode_r <= 1'b0; // RQ7
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel update permission: pin low or override set
   always_ff @(posedge MCLK) begin
      if (RST) begin
         upd_r <= '0;
      end else begin
         upd_r <= mask_r | {NCH{!pin_r[PIN_LOAD]}}; // RQ3 RQ4
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Every completed frame is offered to the rest of the command decoder
   always_ff @(posedge MCLK) begin
      if (RST) begin
         fvalid_r <= 1'b0;
         fword_r  <= '0;
         fabort_r <= 1'b0;
      end else begin
         fvalid_r <= frm.done;
         fabort_r <= clr_fall && in_frame; // RQ7
         if (frm.done) begin
            fword_r <= frm.word;
         end
      end
   end

   // Code is registered so the data output stays glitch free
   always_ff @(posedge MCLK) begin
      if (RST) begin
         CLEAR_CODE <= CODE_ZERO;
      end else begin
         CLEAR_CODE <= code_nxt;
      end
   end

   assign CLEAR_SEL    = sel_r;
   assign UPDATE_MASK  = mask_r;
   assign CLEAR_LOAD   = clr_load_r;
   assign CLEAR_MODE   = clr_mode_r;
   assign CH_UPDATE_EN = upd_r;
   assign FRAME_VALID  = fvalid_r;
   assign FRAME_WORD   = fword_r;
   assign FRAME_ABORT  = fabort_r;
endmodule
`default_nettype wire

/* File: tb/dccum_chk.sv */
// Port assertions for the clear-code and update-mask block
`default_nettype none
module dccum_chk
   import dccum_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        ASYNC_CLEAR_N,
   input wire logic        LOAD_STROBE_N,
   input wire logic [1:0]  CLEAR_SEL,
   input wire logic [3:0]  UPDATE_MASK,
   input wire logic [15:0] CLEAR_CODE,
   input wire logic        CLEAR_LOAD,
   input wire logic        CLEAR_MODE,
   input wire logic [3:0]  CH_UPDATE_EN,
   input wire logic        FRAME_VALID,
   input wire logic [31:0] FRAME_WORD,
   input wire logic        FRAME_ABORT
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////
   sequence s_load;
      CLEAR_LOAD && CLEAR_MODE ##1 !CLEAR_LOAD;
   endsequence
   sequence s_quiet;
      !FRAME_VALID [*8];
   endsequence
   ////////////////////////////////////////
   code_map_a: assert property (
      CLEAR_CODE == (($past(CLEAR_SEL) == SEL_MID) ? CODE_MID :
      ($past(CLEAR_SEL) == SEL_FULL) ? CODE_FULL : CODE_ZERO)) else $error("clear code wrong");
   nop_clear_a: assert property (
      CLEAR_LOAD |-> $past(CLEAR_SEL) != SEL_NOP) else $error("clear fired for no-op");
   clear_fire_a: assert property (
      $fell(ASYNC_CLEAR_N) && CLEAR_SEL != SEL_NOP |-> ##[2:4] s_load)
      else $error("clear pulse missing");
   mode_end_a: assert property (
      FRAME_VALID && !CLEAR_LOAD |-> !CLEAR_MODE) else $error("clear mode kept");
   abort_quiet_a: assert property (
      FRAME_ABORT |=> s_quiet) else $error("aborted frame completed");
   sel_load_a: assert property (
      FRAME_VALID && FRAME_WORD[CMD_HI:CMD_LO] == CMD_CLEAR_CODE
      |-> CLEAR_SEL == FRAME_WORD[SEL_HI:SEL_LO]) else $error("selection not loaded");
   mask_load_a: assert property (
      FRAME_VALID && FRAME_WORD[CMD_HI:CMD_LO] == CMD_UPDATE_MASK
      |-> UPDATE_MASK == FRAME_WORD[MASK_HI:MASK_LO]) else $error("mask not loaded");
   reg_hold_a: assert property (
      !FRAME_VALID |-> $stable(CLEAR_SEL) && $stable(UPDATE_MASK))
      else $error("register changed without frame");
   upd_en_a: assert property (
      $stable(UPDATE_MASK) && $past(LOAD_STROBE_N, 2) == $past(LOAD_STROBE_N, 3)
      && $past(LOAD_STROBE_N, 3) == $past(LOAD_STROBE_N, 4)
      |-> CH_UPDATE_EN == (UPDATE_MASK | {4{!$past(LOAD_STROBE_N, 3)}}))
      else $error("update enable wrong");
   reset_val_a: assert property (disable iff (1'b0)
      RST |=> UPDATE_MASK == MASK_RESET && CLEAR_SEL == SEL_RESET && !CLEAR_MODE)
      else $error("reset value wrong");
endmodule
bind dccum_top dccum_chk chk (.*);
`default_nettype wire

/* File: tb/dccum_host.sv */
// Host model driving the serial command link
`default_nettype none
module dccum_host (
   output var logic sclk,
   output var logic sync_n,
   output var logic sdin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      sdin = 1'b0;
   end
   // Short n leaves the frame early; clock idles high between frames
   task automatic send(input logic [31:0] w, input int n);
      sync_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdin = w[31-i];
         #62.5 sclk = 1'b0;
         #62.5 sclk = 1'b1;
      end
      sync_n = 1'b1;
      sdin = ~sdin; // Released line must not show a stale bit
      #40;
   endtask
endmodule
`default_nettype wire

/* File: tb/test_dac_clear_code_and_update_mask.sv */
// Self-checking bench for the clear-code and update-mask block
`default_nettype none
module test_dac_clear_code_and_update_mask
   import dccum_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        mclk, rst, sclk, sync_n, sdin, clr_n, ld_n;
   logic        cload, cmode, fval, fabort;
   logic [1:0]  sel;
   logic [3:0]  mask, upd;
   logic [15:0] code;
   logic [31:0] fword;
   int          err_count, tests_run;
   dccum_host host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
   dccum_top uut (.MCLK(mclk), .RST(rst), .SCLK(sclk), .SYNC_N(sync_n), .SDIN(sdin),
      .ASYNC_CLEAR_N(clr_n), .LOAD_STROBE_N(ld_n), .CLEAR_SEL(sel), .UPDATE_MASK(mask),
      .CLEAR_CODE(code), .CLEAR_LOAD(cload), .CLEAR_MODE(cmode), .CH_UPDATE_EN(upd),
      .FRAME_VALID(fval), .FRAME_WORD(fword), .FRAME_ABORT(fabort));
   ////////////////////////////////////////
   task automatic chk(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [31:0] w);
      host.send(w, 32);
      cyc(2);
   endtask
   // Eight-cycle window: the pulse is looked for in each of the eight cycles after the pin edge
   task automatic clear_chk(input logic [15:0] exp, input logic fire);
      logic seen;
      logic ab;
      logic exp_ab;
      seen = 1'b0;
      ab = 1'b0;
      cyc(1);
      exp_ab = !sync_n;
      clr_n = 1'b0;
      for (int i = 0; i < 8; i++) begin
         cyc(1);
         if (fabort === 1'b1) begin
            ab = 1'b1;
         end
         if (cload === 1'b1) begin
            seen = 1'b1;
            chk(code === exp, "clear code");
         end
      end
      chk(seen === fire && cmode === fire, "clear pulse or mode");
      chk(ab === exp_ab, "abort pulse");
      clr_n = 1'b1;
      cyc(4);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      chk(sel === SEL_RESET && mask === MASK_RESET && upd === 4'h0, "reset");
      clear_chk(CODE_ZERO, 1'b1);
   endtask
   task automatic t_mask();
      for (int i = 0; i < NCH; i++) begin
         wr({4'hf, CMD_UPDATE_MASK, 8'hff, 12'hfff, 4'h1 << i});
         chk(mask === 4'h1 << i && upd === 4'h1 << i, "mask channel");
      end
      ld_n = 1'b0;
      cyc(5);
      chk(upd === 4'hf, "pin low");
      ld_n = 1'b1;
      cyc(5);
      chk(upd === 4'h8, "pin high");
   endtask
   task automatic t_sel();
      for (int s = 0; s < 4; s++) begin
         wr({4'h0, CMD_CLEAR_CODE, 4'hf, 18'h3ffff, s[1:0]});
         chk(sel === s[1:0] && cmode === 1'b0, "selection");
         clear_chk(s == 1 ? CODE_MID : s == 2 ? CODE_FULL : CODE_ZERO, s != 3);
      end
   endtask
   task automatic t_abort();
      wr({4'h0, CMD_CLEAR_CODE, 24'h1});
      fork
         host.send({4'h0, CMD_CLEAR_CODE, 24'h2}, 32);
         begin
            cyc(100);
            clear_chk(CODE_MID, 1'b1);
         end
      join
      cyc(2);
      chk(sel === SEL_MID, "aborted write");
      host.send({4'h0, CMD_UPDATE_MASK, 24'h5}, 20);
      cyc(2);
      chk(mask === 4'h8 && cmode === 1'b1, "short frame");
   endtask
   task automatic t_other();
      wr({4'h0, 4'h3, 24'h123456});
      chk(cmode === 1'b0 && sel === SEL_MID && mask === 4'h8, "other cmd");
      chk(fword === 32'h03123456, "frame word");
   endtask
   ////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      #400000;
      chk(1'b0, "timeout");
      end_sim();
   end
   initial begin
      rst = 1'b1;
      clr_n = 1'b1;
      ld_n = 1'b1;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge mclk);
      #1 rst = 1'b0;
      cyc(4);
      t_reset();
      t_mask();
      t_sel();
      t_abort();
      t_other();
      end_sim();
   end
endmodule
`default_nettype wire
